// ===== rtl/pag_pkg.sv
// Package: register map, field layout, page map and constants of the access guard
package pag_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int PAGE_W = 8;
    localparam int PWD_W = 32;
    localparam int PASSWORD_ACK_VALUE_W = 16;
    localparam int EXP_W = 3;
    localparam int CNT_W = 8;
    localparam int SIG_IDX_W = 5;
    localparam int SIG_BYTES = 32;

    // ------------------------------------------------------------
    // Register offsets (byte addresses, one word each)
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_PWD = 8'h04;
    localparam logic [ADDR_W-1:0] REG_PASSWORD_ACK_VALUE = 8'h08;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h0C;
    localparam logic [ADDR_W-1:0] REG_INT_STAT = 8'h10;
    localparam logic [ADDR_W-1:0] REG_INT_MASK = 8'h14;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTRL_START_LSB = 0;
    localparam int CTRL_RDPROT_BIT = 8;
    localparam int CTRL_CFGLVL_BIT = 9;
    localparam int CTRL_EXP_LSB = 10;
    localparam int STAT_LOCK_BIT = 0;
    localparam int STAT_AUTH_BIT = 1;
    localparam int INT_W = 4;
    localparam int INT_OK_BIT = 0;
    localparam int INT_FAIL_BIT = 1;
    localparam int INT_LOCK_BIT = 2;
    localparam int INT_DENY_BIT = 3;

    // ------------------------------------------------------------
    // Page map and reset values
    // ------------------------------------------------------------
    localparam logic [PAGE_W-1:0] START_DISABLED = 8'hFF;
    localparam logic [PAGE_W-1:0] LAST_PAGE = 8'hE7;
    localparam logic [PAGE_W-1:0] CFG_FIRST_PAGE = 8'hE2;
    localparam logic [PAGE_W-1:0] PWD_PAGE = 8'hE5;
    localparam logic [PAGE_W-1:0] PASSWORD_ACK_VALUE_PAGE = 8'hE6;
    localparam logic [EXP_W-1:0] EXP_RESET = 3'h0;
    localparam logic [PWD_W-1:0] PWD_RESET = 32'hFFFFFFFF;
    localparam logic [PASSWORD_ACK_VALUE_W-1:0] PASSWORD_ACK_VALUE_RESET = 16'h0000;
    // Signature pattern, arbitrary value held in place of the factory one
    localparam logic [SIG_BYTES*8-1:0] SIGNATURE =
        256'h0F1E2D3C4B5A69788796A5B4C3D2E1F00112233445566778899AABBCCDDEEFF;

    // ------------------------------------------------------------
    // Reader commands and session states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        OP_VERIFY = 2'h0,
        OP_SIGREAD = 2'h1,
        OP_MEMRD = 2'h2,
        OP_MEMWR = 2'h3
    } pag_op_t;

    typedef enum logic [1:0] {
        ST_OPEN = 2'h1,
        ST_AUTH = 2'h2
    } pag_state_t;

    function automatic logic [CNT_W-1:0] pag_fail_limit(input logic [EXP_W-1:0] e);
        pag_fail_limit = CNT_W'(1) << e;
    endfunction : pag_fail_limit

endpackage : pag_pkg

// ===== rtl/pag_fail_counter.sv
// Failed-verification counter with permanent lockout
`timescale 1ns/1ps
module pag_fail_counter (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Control
    input wire logic [pag_pkg::EXP_W-1:0] failLimitExponent,
    input wire logic verifyFail,
    input wire logic verifyPass,
    // Status
    output logic lockout
);

    logic [pag_pkg::CNT_W-1:0] failCount_r;

    // ------------------------------------------------------------
    // Counting
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            failCount_r <= '0;
        end else if (lockout) begin
            failCount_r <= failCount_r;
        end else if (verifyPass) begin
            failCount_r <= '0; // R11
        end else if (verifyFail && failLimitExponent != pag_pkg::EXP_RESET) begin
            if (failCount_r < pag_pkg::pag_fail_limit(failLimitExponent)) begin
                failCount_r <= failCount_r + 8'h01; // R9
            end
        end
    end

    // Lockout never clears short of a reset; a cleared exponent does not reopen it
    always_ff @(posedge clock) begin
        if (rst) begin
            lockout <= 1'b0;
        end else if (verifyFail && failLimitExponent != pag_pkg::EXP_RESET &&
                     failCount_r >= pag_pkg::pag_fail_limit(failLimitExponent)) begin
            lockout <= 1'b1; // R9
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_lock_sticky;
        @(posedge clock) disable iff (rst)
        lockout |=> lockout;
    endproperty
    a_lock_sticky: assert property (p_lock_sticky) else $error("lockout released"); // R9

    property p_no_count_at_zero;
        @(posedge clock) disable iff (rst)
        (failLimitExponent == pag_pkg::EXP_RESET) && verifyFail && !lockout
            |=> $stable(failCount_r) && !lockout;
    endproperty
    a_no_count_at_zero: assert property (p_no_count_at_zero) else $error("counted at 000b"); // R8

endmodule : pag_fail_counter

// ===== rtl/pag_access_guard.sv
// Password access guard: verify, page protection, masked secrets, signature read
// ------------------------------------------------------------
// Overview of operation
// [R1] Start page FFh means no protection at all.
// [R2] Start page inside memory protects that page and all pages above.
// [R3] Holds 32-bit password, 16-bit ack; guards writes or reads and writes.
// [R4] Password and ack stored least significant byte first, as on the link.
// [R5] Reads of password or ack bytes return zero on either interface.
// [R6] Without protection, password and ack are writable any time.
// [R7] With protection, password and ack writable only after successful verify.
// [R8] Exponent 000b disables failure counting; it is the reset value.
// [R9] Failures counted; one beyond two to the exponent locks forever.
// [R10] After lockout every verify fails, even with the right password.
// [R11] Successful verify before lockout clears the failure count.
// [R12] Configuration pages protection level set by its own bit.
// [R13] Configuration pages guarded only when start page is inside memory.
// [R14] 32-byte signature sits in hidden storage, out of reach of reads.
// [R15] Signature read command returns the signature bytes.
// [R16] Read-only lockout flag: 0 while verify possible, 1 once locked.
// [R17] Verify success replies ack and grants access until session end; here a failed verify also ends the access.
// ------------------------------------------------------------
`timescale 1ns/1ps
module pag_access_guard (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Register port
    input wire logic [pag_pkg::ADDR_W-1:0] regAddr,
    input wire logic [pag_pkg::DATA_W-1:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [pag_pkg::DATA_W-1:0] regRdData,
    // Reader command port
    input wire logic cmdValid,
    input wire logic [1:0] cmdOp,
    input wire logic [pag_pkg::PAGE_W-1:0] cmdPage,
    input wire logic [pag_pkg::DATA_W-1:0] cmdData,
    input wire logic sessionEnd,
    // Reader reply port
    output logic respValid,
    output logic respAck,
    output logic respZero,
    output logic [pag_pkg::DATA_W-1:0] respData,
    // Status and interrupt
    output logic verifyLockoutFlag,
    output logic irq
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [pag_pkg::PAGE_W-1:0] protectStartPage_r;
    logic readProtect_r;
    logic configProtectLevel_r;
    logic [pag_pkg::EXP_W-1:0] failLimitExponent_r;
    logic [pag_pkg::PWD_W-1:0] secretPassword_r;
    logic [pag_pkg::PASSWORD_ACK_VALUE_W-1:0] passwordAckValue_r;
    logic [pag_pkg::INT_W-1:0] intStat_r;
    logic [pag_pkg::INT_W-1:0] intMask_r;
    logic lockPrev_r;
    pag_pkg::pag_state_t state_r;
    pag_pkg::pag_state_t state_nxt;
    logic lockout;
    logic protActive;
    logic authed;
    logic secretsWritable;
    logic isVerify;
    logic pwdMatch;
    logic verifyPass;
    logic verifyFail;
    logic memGrant;
    logic memDeny;
    logic [pag_pkg::INT_W-1:0] intSet;

    // ------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------
    function automatic logic inProtRegion(input logic [pag_pkg::PAGE_W-1:0] page);
        inProtRegion = protActive && (page >= protectStartPage_r);
    endfunction : inProtRegion

    function automatic logic isSecretPage(input logic [pag_pkg::PAGE_W-1:0] page);
        isSecretPage = (page == pag_pkg::PWD_PAGE) || (page == pag_pkg::PASSWORD_ACK_VALUE_PAGE);
    endfunction : isSecretPage

    function automatic logic [7:0] sigByte(input logic [pag_pkg::SIG_IDX_W-1:0] idx);
        sigByte = pag_pkg::SIGNATURE[{idx, 3'h0} +: 8];
    endfunction : sigByte

    // Start page FFh or beyond the last page leaves everything open
    assign protActive = (protectStartPage_r != pag_pkg::START_DISABLED) &&
                        (protectStartPage_r <= pag_pkg::LAST_PAGE); // R1 R13
    assign authed = (state_r == pag_pkg::ST_AUTH);
    assign secretsWritable = !protActive || authed; // R6 R7
    assign isVerify = cmdValid && (cmdOp == pag_pkg::OP_VERIFY);
    assign pwdMatch = (cmdData == secretPassword_r); // R4
    assign verifyPass = isVerify && !lockout && pwdMatch;
    assign verifyFail = isVerify && !(!lockout && pwdMatch); // R10

    // ------------------------------------------------------------
    // Access decision
    // ------------------------------------------------------------
    always_comb begin
        memGrant = 1'b1;
        if (cmdOp == pag_pkg::OP_MEMWR) begin
            memGrant = !inProtRegion(cmdPage) || authed; // R2 R3
        end else if (cmdOp == pag_pkg::OP_MEMRD) begin
            if (inProtRegion(cmdPage) && !authed) begin
                if (cmdPage >= pag_pkg::CFG_FIRST_PAGE) begin
                    memGrant = !configProtectLevel_r; // R12 R13
                end else begin
                    memGrant = !readProtect_r; // R3
                end
            end
        end
        memDeny = cmdValid && cmdOp[1] && !memGrant;
    end

    // ------------------------------------------------------------
    // Failure counter
    // ------------------------------------------------------------
    pag_fail_counter u_failCounter (
        .clock(clock),
        .rst(rst),
        .failLimitExponent(failLimitExponent_r),
        .verifyFail(verifyFail),
        .verifyPass(verifyPass),
        .lockout(lockout)
    );

    // ------------------------------------------------------------
    // Session state
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            pag_pkg::ST_OPEN: begin
                if (verifyPass && !sessionEnd) begin
                    state_nxt = pag_pkg::ST_AUTH; // R17
                end
            end
            pag_pkg::ST_AUTH: begin
                if (sessionEnd || verifyFail) begin
                    state_nxt = pag_pkg::ST_OPEN;
                end
            end
            default: begin
                state_nxt = pag_pkg::ST_OPEN;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_r <= pag_pkg::ST_OPEN;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            protectStartPage_r <= pag_pkg::START_DISABLED; // R1
            readProtect_r <= 1'b0;
            configProtectLevel_r <= 1'b0;
            failLimitExponent_r <= pag_pkg::EXP_RESET; // R8
        end else if (regWr && regAddr == pag_pkg::REG_CTRL) begin
            protectStartPage_r <= regWrData[pag_pkg::CTRL_START_LSB +: pag_pkg::PAGE_W];
            readProtect_r <= regWrData[pag_pkg::CTRL_RDPROT_BIT];
            configProtectLevel_r <= regWrData[pag_pkg::CTRL_CFGLVL_BIT]; // R12
            failLimitExponent_r <= regWrData[pag_pkg::CTRL_EXP_LSB +: pag_pkg::EXP_W];
        end
    end

    // Both interfaces may write the secrets; the reader wins a same-cycle clash
    always_ff @(posedge clock) begin
        if (rst) begin
            secretPassword_r <= pag_pkg::PWD_RESET;
            passwordAckValue_r <= pag_pkg::PASSWORD_ACK_VALUE_RESET;
        end else if (secretsWritable) begin
            if (cmdValid && cmdOp == pag_pkg::OP_MEMWR && cmdPage == pag_pkg::PWD_PAGE) begin
                secretPassword_r <= cmdData; // R4 R7
            end else if (regWr && regAddr == pag_pkg::REG_PWD) begin
                secretPassword_r <= regWrData; // R6
            end
            if (cmdValid && cmdOp == pag_pkg::OP_MEMWR && cmdPage == pag_pkg::PASSWORD_ACK_VALUE_PAGE) begin
                passwordAckValue_r <= cmdData[pag_pkg::PASSWORD_ACK_VALUE_W-1:0]; // R4 R7
            end else if (regWr && regAddr == pag_pkg::REG_PASSWORD_ACK_VALUE) begin
                passwordAckValue_r <= regWrData[pag_pkg::PASSWORD_ACK_VALUE_W-1:0]; // R6
            end
        end
    end

    // ------------------------------------------------------------
    // Reader replies
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            respValid <= 1'b0;
            respAck <= 1'b0;
            respZero <= 1'b0;
            respData <= '0;
        end else begin
            respValid <= cmdValid;
            respAck <= 1'b0;
            respZero <= 1'b0;
            respData <= '0;
            if (cmdValid) begin
                case (cmdOp)
                    pag_pkg::OP_VERIFY: begin
                        respAck <= verifyPass; // R10 R17
                        if (verifyPass) begin
                            respData <= {16'h0000, passwordAckValue_r}; // R17
                        end
                    end
                    pag_pkg::OP_SIGREAD: begin
                        respAck <= 1'b1;
                        respData <= {24'h000000, sigByte(cmdPage[pag_pkg::SIG_IDX_W-1:0])}; // R15
                    end
                    pag_pkg::OP_MEMRD: begin
                        respAck <= memGrant;
                        // Page reads never index the signature store
                        respZero <= memGrant && isSecretPage(cmdPage); // R5 R14
                    end
                    default: begin
                        respAck <= memGrant && (!isSecretPage(cmdPage) || secretsWritable);
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    always_comb begin
        intSet = '0;
        intSet[pag_pkg::INT_OK_BIT] = verifyPass;
        intSet[pag_pkg::INT_FAIL_BIT] = verifyFail;
        intSet[pag_pkg::INT_LOCK_BIT] = lockout && !lockPrev_r;
        intSet[pag_pkg::INT_DENY_BIT] = memDeny;
    end

    // A new event outranks a write-one-to-clear in the same cycle
    always_ff @(posedge clock) begin
        if (rst) begin
            intStat_r <= '0;
            intMask_r <= '0;
            lockPrev_r <= 1'b0;
            irq <= 1'b0;
        end else begin
            lockPrev_r <= lockout;
            if (regWr && regAddr == pag_pkg::REG_INT_STAT) begin
                intStat_r <= (intStat_r & ~regWrData[pag_pkg::INT_W-1:0]) | intSet;
            end else begin
                intStat_r <= intStat_r | intSet;
            end
            if (regWr && regAddr == pag_pkg::REG_INT_MASK) begin
                intMask_r <= regWrData[pag_pkg::INT_W-1:0];
            end
            irq <= |(intStat_r & intMask_r);
        end
    end

    // ------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            regRdData <= '0;
            verifyLockoutFlag <= 1'b0;
        end else begin
            verifyLockoutFlag <= lockout; // R16
            regRdData <= '0;
            if (regRd) begin
                case (regAddr)
                    pag_pkg::REG_CTRL: begin
                        regRdData <= {19'h00000, failLimitExponent_r, configProtectLevel_r,
                                      readProtect_r, protectStartPage_r};
                    end
                    pag_pkg::REG_STATUS: begin
                        regRdData <= {30'h00000000, authed, lockout}; // R16
                    end
                    pag_pkg::REG_INT_STAT: begin
                        regRdData <= {28'h0000000, intStat_r};
                    end
                    pag_pkg::REG_INT_MASK: begin
                        regRdData <= {28'h0000000, intMask_r};
                    end
                    default: begin
                        regRdData <= '0; // R5
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_open_when_disabled;
        @(posedge clock) disable iff (rst)
        cmdValid && cmdOp == pag_pkg::OP_MEMRD && protectStartPage_r == pag_pkg::START_DISABLED
            |=> respValid && respAck;
    endproperty
    a_open_when_disabled: assert property (p_open_when_disabled) else $error("denied at FFh"); // R1

    property p_region_guarded;
        @(posedge clock) disable iff (rst)
        cmdValid && cmdOp == pag_pkg::OP_MEMWR && protActive && !authed &&
            cmdPage >= protectStartPage_r |=> respValid && !respAck;
    endproperty
    a_region_guarded: assert property (p_region_guarded) else $error("guarded write let through"); // R2

    property p_secret_reads_zero;
        @(posedge clock) disable iff (rst)
        regRd && (regAddr == pag_pkg::REG_PWD || regAddr == pag_pkg::REG_PASSWORD_ACK_VALUE) |=> regRdData == '0;
    endproperty
    a_secret_reads_zero: assert property (p_secret_reads_zero) else $error("secret leaked"); // R5

    property p_secret_locked;
        @(posedge clock) disable iff (rst)
        protActive && !authed && !(regWr && regAddr == pag_pkg::REG_CTRL)
            |=> $stable(secretPassword_r) && $stable(passwordAckValue_r);
    endproperty
    a_secret_locked: assert property (p_secret_locked) else $error("secret written unverified"); // R7

    property p_lockout_fails;
        @(posedge clock) disable iff (rst)
        lockout && isVerify |=> respValid && !respAck ##1 !authed;
    endproperty
    a_lockout_fails: assert property (p_lockout_fails) else $error("verify passed after lockout"); // R10

    property p_password_ack_value_reply;
        @(posedge clock) disable iff (rst)
        isVerify && !lockout && pwdMatch && !sessionEnd
            |=> respAck && respData[pag_pkg::PASSWORD_ACK_VALUE_W-1:0] == $past(passwordAckValue_r) && authed;
    endproperty
    a_password_ack_value_reply: assert property (p_password_ack_value_reply) else $error("bad verify reply"); // R17

    property p_signature;
        @(posedge clock) disable iff (rst)
        cmdValid && cmdOp == pag_pkg::OP_SIGREAD
            |=> respData[7:0] == sigByte($past(cmdPage[pag_pkg::SIG_IDX_W-1:0]));
    endproperty
    a_signature: assert property (p_signature) else $error("wrong signature byte"); // R15

    property p_lock_flag;
        @(posedge clock) disable iff (rst)
        $rose(lockout) |=> verifyLockoutFlag ##1 verifyLockoutFlag;
    endproperty
    a_lock_flag: assert property (p_lock_flag) else $error("lockout flag missing"); // R16

    property p_irq;
        @(posedge clock) disable iff (rst)
        (intStat_r & intMask_r) != '0 |=> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not raised");

endmodule : pag_access_guard

// ===== test/pag_reader_model.sv
// Reader model: issues commands on the reader port of the guard
`timescale 1ns/1ps
module pag_reader_model (
    // Clock
    input wire logic clock,
    // Command side
    output logic cmdValid,
    output logic [1:0] cmdOp,
    output logic [pag_pkg::PAGE_W-1:0] cmdPage,
    output logic [pag_pkg::DATA_W-1:0] cmdData
);
    initial begin
        cmdValid = 1'h0;
        cmdOp = 2'h0;
        cmdPage = 8'h00;
        cmdData = 32'h0;
    end
    // Link byte 0 sits in bits 7:0, so a word passes through unchanged
    task automatic issue(input logic [1:0] op, input logic [7:0] pg, input logic [31:0] d);
        @(posedge clock);
        cmdValid <= 1'h1;
        cmdOp <= op;
        cmdPage <= pg;
        cmdData <= d;
        @(posedge clock);
        cmdValid <= 1'h0;
        // Released lines show the inverse so stale values never look valid
        cmdPage <= ~pg;
        cmdData <= ~d;
    endtask : issue
endmodule : pag_reader_model

// ===== test/tb_pag_access_guard.sv
// Testbench of the password access guard
`timescale 1ns/1ps
module tb_pag_access_guard;
    logic clock = 1'h0;
    logic rst = 1'h1;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] cmdPage;
    logic [31:0] regWrData = 32'h0;
    logic [31:0] regRdData, cmdData, respData;
    logic regWr = 1'h0;
    logic regRd = 1'h0;
    logic sessionEnd = 1'h0;
    logic cmdValid, respValid, respAck, respZero, verifyLockoutFlag, irq;
    logic [1:0] cmdOp;
    int n_mismatch = 0;
    int tests_run = 0;

    initial forever #50 clock = ~clock;

    pag_reader_model pag_reader_model_inst (.clock(clock), .cmdValid(cmdValid),
        .cmdOp(cmdOp), .cmdPage(cmdPage), .cmdData(cmdData));
    pag_access_guard pag_access_guard_inst (.clock(clock), .rst(rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .cmdValid(cmdValid), .cmdOp(cmdOp), .cmdPage(cmdPage), .cmdData(cmdData),
        .sessionEnd(sessionEnd), .respValid(respValid), .respAck(respAck),
        .respZero(respZero), .respData(respData), .verifyLockoutFlag(verifyLockoutFlag),
        .irq(irq));

    task automatic complete_run;
        $display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'h1;
        @(posedge clock);
        regWr <= 1'h0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock);
        regAddr <= a;
        regRd <= 1'h1;
        @(posedge clock);
        regRd <= 1'h0;
        #1 chk("regRdData", regRdData, exp);
    endtask : rdchk

    // Ops: 0 verify, 1 signature read, 2 memory read, 3 memory write
    task automatic cmd(input logic [1:0] op, input logic [7:0] pg, input logic [31:0] d,
                       input logic ack);
        pag_reader_model_inst.issue(op, pg, d);
        #1 chk("respValid", 32'(respValid), 32'h1);
        chk("respAck", 32'(respAck), 32'(ack));
    endtask : cmd

    task automatic waitchk_irq(input logic exp);
        repeat (2) @(posedge clock);
        #1 chk("irq", 32'(irq), 32'(exp));
    endtask : waitchk_irq

    task automatic t_reset;
        rdchk(pag_pkg::REG_CTRL, 32'h000000FF);
        rdchk(pag_pkg::REG_STATUS, 32'h0);
    endtask : t_reset

    task automatic t_open;
        wr(pag_pkg::REG_PWD, 32'h11223344);
        wr(pag_pkg::REG_PASSWORD_ACK_VALUE, 32'h00005A5A);
        rdchk(pag_pkg::REG_PWD, 32'h0);
        rdchk(pag_pkg::REG_PASSWORD_ACK_VALUE, 32'h0);
        rdchk(8'h40, 32'h0);
        cmd(2'h3, 8'h20, 32'h0, 1'h1);
        cmd(2'h2, 8'h20, 32'h0, 1'h1);
        repeat (3) cmd(2'h0, 8'h00, 32'h0, 1'h0);
        rdchk(pag_pkg::REG_STATUS, 32'h0);
    endtask : t_open

    task automatic t_protect;
        // Start page 10h, config pages read guarded, exponent 1
        wr(pag_pkg::REG_CTRL, 32'h00000610);
        cmd(2'h3, 8'h10, 32'h0, 1'h0);
        cmd(2'h3, 8'h0F, 32'h0, 1'h1);
        cmd(2'h2, 8'h10, 32'h0, 1'h1);
        cmd(2'h2, pag_pkg::CFG_FIRST_PAGE, 32'h0, 1'h0);
        wr(pag_pkg::REG_PWD, 32'h55667788);
        cmd(2'h0, 8'h00, 32'h11223344, 1'h1);
        chk("respData", respData, 32'h00005A5A);
        cmd(2'h3, 8'h10, 32'h0, 1'h1);
        cmd(2'h2, pag_pkg::PWD_PAGE, 32'h0, 1'h1);
        chk("respZero", 32'(respZero), 32'h1);
        chk("respData", respData, 32'h0);
        wr(pag_pkg::REG_PWD, 32'h04030201);
        wr(pag_pkg::REG_PASSWORD_ACK_VALUE, 32'h0000BEEF);
        @(posedge clock);
        sessionEnd <= 1'h1;
        @(posedge clock);
        sessionEnd <= 1'h0;
        cmd(2'h3, 8'h10, 32'h0, 1'h0);
        cmd(2'h0, 8'h00, 32'h04030201, 1'h1);
        chk("respData", respData, 32'h0000BEEF);
    endtask : t_protect

    task automatic t_irq;
        wr(pag_pkg::REG_INT_MASK, 32'h1);
        wr(pag_pkg::REG_INT_STAT, 32'h1);
        rdchk(pag_pkg::REG_INT_STAT, 32'hA);
        waitchk_irq(1'h0);
        cmd(2'h0, 8'h00, 32'h04030201, 1'h1);
        waitchk_irq(1'h1);
        wr(pag_pkg::REG_INT_STAT, 32'h1);
        waitchk_irq(1'h0);
    endtask : t_irq

    task automatic t_sig;
        cmd(2'h1, 8'h00, 32'h0, 1'h1);
        chk("respData", respData, 32'(pag_pkg::SIGNATURE[7:0]));
        cmd(2'h1, 8'h1F, 32'h0, 1'h1);
        chk("respData", respData, 32'(pag_pkg::SIGNATURE[255:248]));
        cmd(2'h2, 8'h00, 32'h0, 1'h1);
        chk("respData", respData, 32'h0);
    endtask : t_sig

    task automatic t_lock;
        cmd(2'h0, 8'h00, 32'h0, 1'h0);
        cmd(2'h0, 8'h00, 32'h04030201, 1'h1);
        cmd(2'h0, 8'h00, 32'h0, 1'h0);
        cmd(2'h0, 8'h00, 32'h0, 1'h0);
        rdchk(pag_pkg::REG_STATUS, 32'h0);
        cmd(2'h0, 8'h00, 32'h0, 1'h0);
        repeat (2) @(posedge clock);
        #1 chk("verifyLockoutFlag", 32'(verifyLockoutFlag), 32'h1);
        rdchk(pag_pkg::REG_STATUS, 32'h1);
        cmd(2'h0, 8'h00, 32'h04030201, 1'h0);
        cmd(2'h3, 8'h10, 32'h0, 1'h0);
        // Read protect on: user pages from the start page up need a session too
        wr(pag_pkg::REG_CTRL, 32'h00000710);
        cmd(2'h2, 8'h10, 32'h0, 1'h0);
        rdchk(pag_pkg::REG_INT_STAT, 32'hF);
        // Only a reset clears the lockout
        @(posedge clock);
        rst <= 1'h1;
        repeat (2) @(posedge clock);
        rst <= 1'h0;
        rdchk(pag_pkg::REG_STATUS, 32'h0);
        chk("verifyLockoutFlag", 32'(verifyLockoutFlag), 32'h0);
        rdchk(pag_pkg::REG_CTRL, 32'h000000FF);
    endtask : t_lock

    initial begin
        repeat (12) @(posedge clock);
        rst <= 1'h0;
        t_reset;
        t_open;
        t_protect;
        t_irq;
        t_sig;
        t_lock;
        complete_run;
    end

    // Hang guard
    initial begin
        #5000000;
        n_mismatch++;
        complete_run;
    end
endmodule : tb_pag_access_guard
